/* File: dcg_regs.vh */
// register map constants for the channel-one gain and output configuration bank
// assumes an 8-bit internal register port decoded by the control-port front end
`ifndef DCG_REGS_VH
`define DCG_REGS_VH
`define DCG_ADDR_OUTCFG      8'h66
`define DCG_ADDR_AVOL        8'h67
`define DCG_ADDR_AFINE       8'h68
`define DCG_ADDR_BVOL        8'h69
`define DCG_RST_OUTCFG       8'h20
`define DCG_RST_VOL          8'hC9
`define DCG_RST_AFINE        8'h80
`define DCG_RST_FINE_CODE    4'h8
`define DCG_RST_BW           1'b0
`define DCG_LVL_RESERVED     3'h7
`define DCG_VOL_MUTE         8'h00
`define DCG_VOL_UNITY        8'hC9
`define DCG_FINE_UNITY       4'h8
`define DCG_RSVD_ZERO        4'h0
// gain in 0.1 dB units; volume step is 5 tenths, sized so the product stays 12 bits
`define DCG_VOL_STEP_TENTHS  12'sh005
`define DCG_GAIN_W           12
`define DCG_RST_DRV          2'h0
`define DCG_RST_LVL          3'h4
`define DCG_RST_IMP          1'h0
`define DCG_RST_FS           1'h0
`define DCG_RST_CMT          1'h0
`define DCG_RST_FLAG         1'h0
`define DCG_RD_IDLE          8'h00
`define DCG_DRV_MSB          7
`define DCG_DRV_LSB          6
`define DCG_LVL_MSB          5
`define DCG_LVL_LSB          3
`define DCG_IMP_BIT          2
`define DCG_FS_BIT           1
`define DCG_CMT_BIT          0
`define DCG_FINE_MSB         7
`define DCG_FINE_LSB         4
`define DCG_SUB_CNT          2
`endif

/* File: dcg_gain_calc.v */
// combines volume code and fine gain code into a total gain in 0.1 dB units
// assumes the caller registers the result
`timescale 1ns/1ps
`include "dcg_regs.vh"
module dcg_gain_calc (
  // codes
  input  wire [7:0]                   volCode,
  input  wire [3:0]                   fineCode,
  // result
  output wire                         mute,
  output wire signed [`DCG_GAIN_W-1:0] gainTenths
);
  wire signed [`DCG_GAIN_W-1:0] volPart;
  wire signed [`DCG_GAIN_W-1:0] finePart;

  assign mute = (volCode == `DCG_VOL_MUTE);
  // 0.5 dB per code, unity at 201 so code 1 is -100 dB and 255 is +27 dB
  assign volPart = ($signed({4'h0, volCode}) - $signed({4'h0, `DCG_VOL_UNITY}))
                   * `DCG_VOL_STEP_TENTHS;
  assign finePart = $signed({8'h00, fineCode}) - $signed({8'h00, `DCG_FINE_UNITY});
  // muted channels report zero gain, the mute flag governs the path
  assign gainTenths = mute ? {`DCG_GAIN_W{1'b0}} : volPart + finePart;
endmodule // dcg_gain_calc

/* File: dcg_chan_cfg.v */
// channel-one gain and output configuration register bank with gain outputs
// assumes a synchronous byte-wide register port from the control-port decoder
`timescale 1ns/1ps
`include "dcg_regs.vh"
module dcg_chan_cfg (
  // clock and reset
  input  wire                          sys_clk,
  input  wire                          rstn,
  // register port
  input  wire                          regWrEn,
  input  wire                          regRdEn,
  input  wire [7:0]                    regAddr,
  input  wire [7:0]                    regWrData,
  output reg  [7:0]                    regRdData,
  output reg                           regHit,
  // bandwidth select from the neighbouring configuration register
  input  wire                          channelBandwidthSelect,
  // analog output configuration
  output reg  [1:0]                    minusSideDriverType,
  output reg  [2:0]                    minusSideLevel,
  output reg                           plusBypassInputImpedance,
  output reg                           channelFullscaleSelect,
  output reg                           commonModeToleranceSelect,
  output reg                           wideBandwidth,
  output reg                           fullscaleConflict,
  output reg                           levelReserved,
  // digital gain stage
  output reg  [7:0]                    subAVolumeCode,
  output reg  [7:0]                    subBVolumeCode,
  output reg  [3:0]                    subAFineGainCode,
  output reg                           subAMute,
  output reg                           subBMute,
  output reg  signed [`DCG_GAIN_W-1:0] subAGain,
  output reg  signed [`DCG_GAIN_W-1:0] subBGain
);
  // output configuration fields, kept apart so each has its own reset value
  reg  [1:0]                    driveField;
  reg  [2:0]                    levelField;
  reg                           impField;
  reg                           fsField;
  reg                           cmtField;
  // register port decode
  wire                          wrOutCfg;
  wire                          wrAVol;
  wire                          wrAFine;
  wire                          wrBVol;
  wire                          anyAccess;
  wire [7:0]                    outCfgView;
  wire [7:0]                    fineView;
  reg  [7:0]                    next_regRdData;
  reg                           next_regHit;
  // per sub-channel gain buses, sub-channel A in the low slice
  wire [`DCG_SUB_CNT*8-1:0]     volBus;
  wire [`DCG_SUB_CNT*4-1:0]     fineBus;
  wire [`DCG_SUB_CNT-1:0]       muteBus;
  wire [`DCG_SUB_CNT*`DCG_GAIN_W-1:0] gainBus;
  genvar                        gi;

  assign wrOutCfg   = regWrEn & (regAddr == `DCG_ADDR_OUTCFG);
  assign wrAVol     = regWrEn & (regAddr == `DCG_ADDR_AVOL);
  assign wrAFine    = regWrEn & (regAddr == `DCG_ADDR_AFINE);
  assign wrBVol     = regWrEn & (regAddr == `DCG_ADDR_BVOL);
  assign anyAccess  = regRdEn | regWrEn;
  assign outCfgView = {driveField, levelField, impField, fsField, cmtField};
  // low nibble is never stored, so it reads zero whatever the host wrote
  assign fineView   = {subAFineGainCode, `DCG_RSVD_ZERO};

  // output configuration register
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      driveField <= `DCG_RST_DRV;
      levelField <= `DCG_RST_LVL;
      impField   <= `DCG_RST_IMP;
      fsField    <= `DCG_RST_FS;
      cmtField   <= `DCG_RST_CMT;
    end
    else if (wrOutCfg)
    begin
      driveField <= regWrData[`DCG_DRV_MSB:`DCG_DRV_LSB];
      // level 7 is stored as written and flagged below, not refused
      levelField <= regWrData[`DCG_LVL_MSB:`DCG_LVL_LSB];
      impField   <= regWrData[`DCG_IMP_BIT];
      fsField    <= regWrData[`DCG_FS_BIT];
      cmtField   <= regWrData[`DCG_CMT_BIT];
    end
  end

  // sub-channel A volume
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      subAVolumeCode <= `DCG_RST_VOL;
    end
    else if (wrAVol)
    begin
      subAVolumeCode <= regWrData;
    end
  end

  // sub-channel A fine gain
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      subAFineGainCode <= `DCG_RST_FINE_CODE;
    end
    else if (wrAFine)
    begin
      subAFineGainCode <= regWrData[`DCG_FINE_MSB:`DCG_FINE_LSB];
    end
  end

  // sub-channel B volume
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      subBVolumeCode <= `DCG_RST_VOL;
    end
    else if (wrBVol)
    begin
      subBVolumeCode <= regWrData;
    end
  end

  // read decode; unmapped addresses answer zero with no hit
  always @*
  begin
    next_regRdData = `DCG_RD_IDLE;
    next_regHit    = 1'h1;
    case (regAddr)
      `DCG_ADDR_OUTCFG:
      begin
        next_regRdData = outCfgView;
      end
      `DCG_ADDR_AVOL:
      begin
        next_regRdData = subAVolumeCode;
      end
      `DCG_ADDR_AFINE:
      begin
        next_regRdData = fineView;
      end
      `DCG_ADDR_BVOL:
      begin
        next_regRdData = subBVolumeCode;
      end
      default:
      begin
        next_regHit = 1'h0;
      end
    endcase
  end

  assign volBus  = {subBVolumeCode, subAVolumeCode};
  // sub-channel B fine gain lives outside this bank, so it runs at unity
  assign fineBus = {`DCG_FINE_UNITY, subAFineGainCode};

  generate
    for (gi = 0; gi < `DCG_SUB_CNT; gi = gi + 1)
    begin : gSub
      dcg_gain_calc dcg_gain_calc_i (
        .volCode    (volBus[gi*8 +: 8]),
        .fineCode   (fineBus[gi*4 +: 4]),
        .mute       (muteBus[gi]),
        .gainTenths (gainBus[gi*`DCG_GAIN_W +: `DCG_GAIN_W])
      );
    end
  endgenerate

  // register port answer, one cycle after the taking edge
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regRdData <= `DCG_RD_IDLE;
      regHit    <= `DCG_RST_FLAG;
    end
    else
    begin
      regRdData <= regRdEn ? next_regRdData : `DCG_RD_IDLE;
      regHit    <= anyAccess & next_regHit;
    end
  end

  // analog configuration copies; one cycle behind storage keeps them glitch free
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      minusSideDriverType       <= `DCG_RST_DRV;
      minusSideLevel            <= `DCG_RST_LVL;
      plusBypassInputImpedance  <= `DCG_RST_IMP;
      channelFullscaleSelect    <= `DCG_RST_FS;
      commonModeToleranceSelect <= `DCG_RST_CMT;
      wideBandwidth             <= `DCG_RST_BW;
      fullscaleConflict         <= `DCG_RST_FLAG;
      levelReserved             <= `DCG_RST_FLAG;
    end
    else
    begin
      minusSideDriverType       <= driveField;
      minusSideLevel            <= levelField;
      plusBypassInputImpedance  <= impField;
      channelFullscaleSelect    <= fsField;
      commonModeToleranceSelect <= cmtField;
      wideBandwidth             <= channelBandwidthSelect;
      // higher full scale only holds in audio bandwidth; misuse is flagged, not blocked
      fullscaleConflict         <= fsField & channelBandwidthSelect;
      levelReserved             <= (levelField == `DCG_LVL_RESERVED);
    end
  end

  // digital gain stage copies
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      subAMute <= `DCG_RST_FLAG;
      subBMute <= `DCG_RST_FLAG;
      subAGain <= {`DCG_GAIN_W{1'h0}};
      subBGain <= {`DCG_GAIN_W{1'h0}};
    end
    else
    begin
      subAMute <= muteBus[0];
      subBMute <= muteBus[1];
      subAGain <= gainBus[`DCG_GAIN_W-1:0];
      subBGain <= gainBus[2*`DCG_GAIN_W-1:`DCG_GAIN_W];
    end
  end
endmodule // dcg_chan_cfg

/* File: dcg_chk.sv */
// assertions on the channel-one register bank ports
// assumes a bind into dcg_chan_cfg, one clock domain
`timescale 1ns/1ps
module dcg_chk (
  // clock and reset
  input wire               sys_clk,
  input wire               rstn,
  // register port
  input wire               regWrEn,
  input wire               regRdEn,
  input wire [7:0]         regAddr,
  input wire [7:0]         regWrData,
  input wire [7:0]         regRdData,
  input wire               regHit,
  // gain stage
  input wire [7:0]         subAVolumeCode,
  input wire [7:0]         subBVolumeCode,
  input wire [3:0]         subAFineGainCode,
  input wire               subAMute,
  input wire signed [11:0] subAGain,
  input wire signed [11:0] subBGain
);
  wire mapped = regAddr >= 8'h66 && regAddr <= 8'h69;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_hit; regRdEn && mapped |=> regHit; endproperty
  a_hit: assert property (p_hit) else $error("no hit");
  property p_unm; (regRdEn || regWrEn) && !mapped |=> !regHit && regRdData == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped answered");
  property p_rsv; regRdEn && regAddr == 8'h68 |=> regRdData[3:0] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_mute; subAVolumeCode == 8'h00 |=> subAMute && subAGain == 0; endproperty
  a_mute: assert property (p_mute) else $error("no mute");
  property p_bgn; subBVolumeCode != 8'h00 |=> subBGain == ($signed({5'h00, $past(subBVolumeCode)}) - 201) * 5;
  endproperty
  a_bgn: assert property (p_bgn) else $error("b gain wrong");
  property p_agn; subAVolumeCode != 8'h00 |=> subAGain == ($signed({5'h00, $past(subAVolumeCode)}) - 201) * 5
    + $signed({1'b0, $past(subAFineGainCode)}) - 8; endproperty
  a_agn: assert property (p_agn) else $error("a gain wrong");
  property p_wra; regWrEn && regAddr == 8'h67 |=> subAVolumeCode == $past(regWrData); endproperty
  a_wra: assert property (p_wra) else $error("a volume not stored");
  property p_wrb; regWrEn && regAddr == 8'h69 |=> subBVolumeCode == $past(regWrData); endproperty
  a_wrb: assert property (p_wrb) else $error("b volume not stored");
  property p_fin; regWrEn && regAddr == 8'h68 |=> subAFineGainCode == $past(regWrData[7:4]); endproperty
  a_fin: assert property (p_fin) else $error("fine gain not stored");
  c_mute: cover property (regWrEn && regAddr == 8'h67 && regWrData == 8'h00);
  c_unm: cover property (regRdEn && !mapped);
  c_hit: cover property (regHit);
endmodule // dcg_chk

/* File: dcg_host.sv */
// host model driving the byte-wide register port
// assumes the bench calls wr and rd one at a time
`timescale 1ns/1ps
module dcg_host (
  // clock
  input  wire        sys_clk,
  // register port
  output logic       regWrEn,
  output logic       regRdEn,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  input  wire  [7:0] regRdData,
  input  wire        regHit
);
  initial {regWrEn, regRdEn, regAddr, regWrData} = 18'h0;
  // released lines carry the inverse so no stale value looks valid
  task wr(input logic [7:0] a, input logic [7:0] wd);
    @(posedge sys_clk) #1;
    {regWrEn, regAddr, regWrData} = {1'b1, a, wd};
    @(posedge sys_clk) #1;
    {regWrEn, regAddr, regWrData} = {1'b0, ~a, ~wd};
  endtask
  task rd(input logic [7:0] a, output logic [7:0] rdv, output logic hit);
    @(posedge sys_clk) #1;
    {regRdEn, regAddr} = {1'b1, a};
    @(posedge sys_clk) #1;
    {regRdEn, regAddr, rdv, hit} = {1'b0, ~a, regRdData, regHit};
  endtask
endmodule // dcg_host

/* File: tb.sv */
// self-checking bench for the channel-one register bank
// assumes dcg_host drives the register port and dcg_chk is bound in
`timescale 1ns/1ps
bind dcg_chan_cfg dcg_chk dcg_chk_i (.sys_clk, .rstn, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
  .regHit, .subAVolumeCode, .subBVolumeCode, .subAFineGainCode, .subAMute, .subAGain, .subBGain);
module tb;
  logic sys_clk = 0, rstn = 0, channelBandwidthSelect = 0, h;
  logic regWrEn, regRdEn, regHit, plusBypassInputImpedance, channelFullscaleSelect, commonModeToleranceSelect;
  logic wideBandwidth, fullscaleConflict, levelReserved, subAMute, subBMute;
  logic [7:0] regAddr, regWrData, regRdData, subAVolumeCode, subBVolumeCode, d;
  logic [3:0] subAFineGainCode;
  logic [2:0] minusSideLevel;
  logic [1:0] minusSideDriverType;
  logic signed [11:0] subAGain, subBGain, g;
  logic [7:0] rv [4] = '{8'h20, 8'hC9, 8'h80, 8'hC9};
  int vt [6] = '{0, 1, 2, 201, 202, 255};
  int error_cnt = 0, checks_done = 0, cyc = 0, i;
  dcg_chan_cfg dcg_chan_cfg_i (.sys_clk, .rstn, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regHit,
    .channelBandwidthSelect, .minusSideDriverType, .minusSideLevel, .plusBypassInputImpedance,
    .channelFullscaleSelect, .commonModeToleranceSelect, .wideBandwidth, .fullscaleConflict, .levelReserved,
    .subAVolumeCode, .subBVolumeCode, .subAFineGainCode, .subAMute, .subBMute, .subAGain, .subBGain);
  dcg_host dcg_host_i (.sys_clk, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regHit);
  initial forever #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    if (++cyc == 3000)
    begin
      error_cnt++;
      test_done;
    end
  end
  task test_done;
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    #1 rstn = 1;
    for (i = 0; i < 4; i++)
    begin
      dcg_host_i.rd(8'h66 + i, d, h);
      chk({h, d}, {1'b1, rv[i]});
    end
    // level 7 included on purpose: stored and flagged, not blocked
    for (i = 0; i < 8; i++)
    begin
      dcg_host_i.wr(8'h66, {i[1:0], i[2:0], i[2:0]});
      dcg_host_i.rd(8'h66, d, h);
      chk(d, {i[1:0], i[2:0], i[2:0]});
      chk({minusSideDriverType, minusSideLevel}, {i[1:0], i[2:0]});
      chk({plusBypassInputImpedance, channelFullscaleSelect, commonModeToleranceSelect}, i[2:0]);
      chk(levelReserved, i == 7);
    end
    channelBandwidthSelect = 1;
    dcg_host_i.rd(8'h66, d, h);
    chk({wideBandwidth, fullscaleConflict}, 2'h3);
    // reserved low nibble is written as zero, as the host must
    dcg_host_i.wr(8'h68, 8'h30);
    dcg_host_i.rd(8'h68, d, h);
    chk({subAFineGainCode, d}, {4'h3, 8'h30});
    for (i = 0; i < 6; i++)
    begin
      dcg_host_i.wr(8'h67, vt[i]);
      dcg_host_i.wr(8'h69, vt[i]);
      dcg_host_i.rd(8'h67, d, h);
      chk(d, vt[i]);
      g = vt[i] ? (vt[i] - 201) * 5 : 0;
      chk(subBGain, g);
      chk(subAGain, vt[i] ? g - 5 : 0);
      chk({subAMute, subBMute}, vt[i] ? 0 : 3);
    end
    for (i = 0; i < 2; i++)
    begin
      dcg_host_i.wr(i ? 8'h6A : 8'h65, 8'h55);
      dcg_host_i.rd(i ? 8'h6A : 8'h65, d, h);
      chk({h, d}, 0);
    end
    dcg_host_i.rd(8'h69, d, h);
    chk(d, 8'hFF);
    test_done;
  end
endmodule // tb
